// ### rtl/afe_muxed_iq_data_port.sv
`timescale 1ns/1ps
`default_nettype none
module afe_muxed_iq_data_port
  import afe_port_pkg::*;
(
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire logic              conv_clk_i,
  input  wire logic              tx_select_i,
  input  wire logic              power_off_state_n_i,
  input  wire logic              idle_state_i,
  input  wire logic              low_power_hold_state_i,
  input  wire logic              full_scale_sel_i,
  input  wire logic [TRIM_W-1:0] inphase_trim_i,
  input  wire logic [TRIM_W-1:0] quadrature_trim_i,
  input  wire logic [BUS_W-1:0]  inphase_rx_channel_i,
  input  wire logic [BUS_W-1:0]  quadrature_rx_channel_i,
  input  wire logic [BUS_W-1:0]  shared_sample_bus_i,
  output logic      [BUS_W-1:0]  shared_sample_bus_o,
  output logic                   shared_sample_bus_oe_o,
  output logic                   shared_sample_bus_pullup_o,
  input  wire logic              dac_ready_i,
  output logic                   dac_valid_o,
  output logic      [BUS_W-1:0]  inphase_tx_sample_o,
  output logic      [BUS_W-1:0]  quadrature_tx_sample_o,
  output logic                   tx_update_o,
  output logic                   tx_overrun_o,
  output logic                   full_scale_sel_o,
  output logic      [TRIM_W-1:0] inphase_trim_o,
  output logic      [TRIM_W-1:0] quadrature_trim_o
);

  // converter samples arrive two's complement; flipping the sign bit gives offset binary
  function automatic logic [BUS_W-1:0] to_offset_binary(input logic [BUS_W-1:0] v);
    to_offset_binary = {~v[BUS_W-1], v[BUS_W-2:0]};
  endfunction

  logic             conv_prev_reg;
  port_mode_e       mode_reg;
  port_mode_e       mode_next;
  logic [BUS_W-1:0] pipe_i_reg [RX_PIPE_DEPTH];
  logic [BUS_W-1:0] pipe_q_reg [RX_PIPE_DEPTH];
  logic [BUS_W-1:0] q_hold_reg;
  logic [BUS_W-1:0] bus_out_reg;
  logic [BUS_W-1:0] tx_i_hold_reg;
  logic             tx_i_taken_reg;
  logic [2*BUS_W-1:0] txbuf_reg [TXBUF_DEPTH];
  logic             txbuf_wr_reg;
  logic             txbuf_rd_reg;
  logic [TXBUF_CNT_W-1:0] txbuf_cnt_reg;
  logic [BUS_W-1:0] tx_i_out_reg;
  logic [BUS_W-1:0] tx_q_out_reg;
  logic             tx_update_reg;
  logic             tx_overrun_reg;
  logic             fs_sel_reg;
  logic [TRIM_W-1:0] trim_i_reg;
  logic [TRIM_W-1:0] trim_q_reg;

  // conversion clock is a plain synchronous input; its edges are events here
  wire conv_rise = conv_clk_i & ~conv_prev_reg;
  wire conv_fall = ~conv_clk_i & conv_prev_reg;
  wire quiet     = ~power_off_state_n_i | idle_state_i | low_power_hold_state_i;

  assign mode_next = quiet ? MODE_QUIET : (tx_select_i ? MODE_TX : MODE_RX);

  wire in_rx = (mode_reg == MODE_RX);
  wire in_tx = (mode_reg == MODE_TX);

  // tx buffer handshakes: fill side is the pair capture, drain side the dac update
  wire txbuf_full  = (txbuf_cnt_reg == TXBUF_FULL);
  wire txbuf_valid = (txbuf_cnt_reg != '0);
  wire txbuf_pop   = conv_rise & txbuf_valid & dac_ready_i;
  wire txbuf_ready = ~txbuf_full | txbuf_pop;
  wire pair_done   = in_tx & conv_rise & tx_i_taken_reg;
  wire txbuf_push  = pair_done & txbuf_ready;
  wire [2*BUS_W-1:0] txbuf_head = txbuf_reg[txbuf_rd_reg];

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      conv_prev_reg <= 1'b0;
      mode_reg      <= MODE_QUIET;
    end else begin
      conv_prev_reg <= conv_clk_i;
      mode_reg      <= mode_next;
    end
  end

  // rx pipeline: both channels captured on the same rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int k = 0; k < RX_PIPE_DEPTH; k++) begin
        pipe_i_reg[k] <= MIDSCALE_CODE;
        pipe_q_reg[k] <= MIDSCALE_CODE;
      end
      q_hold_reg <= MIDSCALE_CODE;
    end else if (conv_rise) begin
      pipe_i_reg[0] <= to_offset_binary(inphase_rx_channel_i);
      pipe_q_reg[0] <= to_offset_binary(quadrature_rx_channel_i);
      for (int k = 1; k < RX_PIPE_DEPTH; k++) begin
        pipe_i_reg[k] <= pipe_i_reg[k-1];
        pipe_q_reg[k] <= pipe_q_reg[k-1];
      end
      q_hold_reg <= pipe_q_reg[RX_PIPE_LAST];
    end
  end

  // output latch: in-phase on rising, quadrature half a cycle later
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bus_out_reg <= BUS_RST;
    end else if (conv_rise) begin
      bus_out_reg <= pipe_i_reg[RX_PIPE_LAST];
    end else if (conv_fall) begin
      bus_out_reg <= q_hold_reg;
    end
  end

  // driver enable follows the registered mode, so a direction change releases the bus
  // within one system cycle; the host must already be off the bus by then
  assign shared_sample_bus_o        = bus_out_reg;
  assign shared_sample_bus_oe_o     = in_rx;
  assign shared_sample_bus_pullup_o = (mode_reg == MODE_QUIET);

  // tx capture: in-phase on falling, quadrature on the following rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_i_hold_reg  <= MIDSCALE_CODE;
      tx_i_taken_reg <= 1'b0;
    end else if (!in_tx) begin
      tx_i_taken_reg <= 1'b0;
    end else if (conv_fall) begin
      tx_i_hold_reg  <= shared_sample_bus_i;
      tx_i_taken_reg <= 1'b1;
    end else if (conv_rise) begin
      tx_i_taken_reg <= 1'b0;
    end
  end

  // two-entry pair buffer: a stalled dac keeps up to two pairs, a third is dropped
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      txbuf_wr_reg  <= 1'b0;
      txbuf_rd_reg  <= 1'b0;
      txbuf_cnt_reg <= '0;
      for (int k = 0; k < TXBUF_DEPTH; k++) begin
        txbuf_reg[k] <= {MIDSCALE_CODE, MIDSCALE_CODE};
      end
    end else begin
      if (txbuf_push) begin
        txbuf_reg[txbuf_wr_reg] <= {tx_i_hold_reg, shared_sample_bus_i};
        txbuf_wr_reg            <= ~txbuf_wr_reg;
      end
      if (txbuf_pop) begin
        txbuf_rd_reg <= ~txbuf_rd_reg;
      end
      if (txbuf_push && !txbuf_pop) begin
        txbuf_cnt_reg <= txbuf_cnt_reg + 2'h1;
      end else if (txbuf_pop && !txbuf_push) begin
        txbuf_cnt_reg <= txbuf_cnt_reg - 2'h1;
      end
    end
  end

  // both dac words change on one edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_i_out_reg   <= MIDSCALE_CODE;
      tx_q_out_reg   <= MIDSCALE_CODE;
      tx_update_reg  <= 1'b0;
      tx_overrun_reg <= 1'b0;
    end else begin
      tx_update_reg  <= txbuf_pop;
      tx_overrun_reg <= pair_done & ~txbuf_ready;
      if (txbuf_pop) begin
        tx_i_out_reg <= txbuf_head[2*BUS_W-1:BUS_W];
        tx_q_out_reg <= txbuf_head[BUS_W-1:0];
      end
    end
  end

  // analog trim and full-scale settings, held for the output buffers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fs_sel_reg <= FS_SEL_410MV;
      trim_i_reg <= TRIM_RST;
      trim_q_reg <= TRIM_RST;
    end else begin
      fs_sel_reg <= full_scale_sel_i;
      trim_i_reg <= inphase_trim_i;
      trim_q_reg <= quadrature_trim_i;
    end
  end

  assign dac_valid_o            = txbuf_valid;
  assign inphase_tx_sample_o    = tx_i_out_reg;
  assign quadrature_tx_sample_o = tx_q_out_reg;
  assign tx_update_o            = tx_update_reg;
  assign tx_overrun_o           = tx_overrun_reg;
  assign full_scale_sel_o       = fs_sel_reg;
  assign inphase_trim_o         = trim_i_reg;
  assign quadrature_trim_o      = trim_q_reg;

  AST_OE_RX_ONLY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    shared_sample_bus_oe_o |-> $past(!quiet && !tx_select_i) && !shared_sample_bus_pullup_o)
    else $error("bus driven outside rx mode");

  AST_QUIET_PULLUP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    quiet |=> shared_sample_bus_pullup_o && !shared_sample_bus_oe_o)
    else $error("bus not pulled up in a low-power state");

  AST_DIR_SELECT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!quiet && !tx_select_i) |=> shared_sample_bus_oe_o)
    else $error("direction low did not give rx mode");

  AST_SAMPLE_CODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_rise |=> pipe_i_reg[0] == {~$past(inphase_rx_channel_i[BUS_W-1]),
                                    $past(inphase_rx_channel_i[BUS_W-2:0])}
             && pipe_q_reg[0] == {~$past(quadrature_rx_channel_i[BUS_W-1]),
                                  $past(quadrature_rx_channel_i[BUS_W-2:0])})
    else $error("rx sample not captured in offset binary");

  AST_I_ON_RISE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_rise |=> shared_sample_bus_o == $past(pipe_i_reg[RX_PIPE_LAST]))
    else $error("in-phase word not latched on rising edge");

  AST_Q_ON_FALL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_fall |=> shared_sample_bus_o == $past(q_hold_reg))
    else $error("quadrature word not latched on falling edge");

  AST_TX_I_FALL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (in_tx && conv_fall) |=> tx_i_taken_reg && tx_i_hold_reg == $past(shared_sample_bus_i))
    else $error("in-phase tx word not taken on falling edge");

  AST_TX_UPDATE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    tx_update_o |-> $past(conv_rise) && $past(dac_ready_i) && $past(txbuf_valid))
    else $error("dac update away from a rising edge");

  AST_NO_OVERFILL: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (txbuf_full && !txbuf_pop) |=> txbuf_cnt_reg == TXBUF_FULL)
    else $error("tx buffer count passed full");

  AST_SETTINGS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 full_scale_sel_o == $past(full_scale_sel_i) && inphase_trim_o == $past(inphase_trim_i))
    else $error("analog settings not following inputs");

  AST_TRIM_Q: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 quadrature_trim_o == $past(quadrature_trim_i))
    else $error("quadrature trim not following its input");

  AST_TX_DECODE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!quiet && tx_select_i) |=> !shared_sample_bus_oe_o && !shared_sample_bus_pullup_o)
    else $error("direction high did not give tx mode");

  AST_PIPE_SHIFT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_rise |=> pipe_i_reg[RX_PIPE_LAST] == $past(pipe_i_reg[RX_PIPE_LAST-1]))
    else $error("rx pipeline did not advance on a rising edge");

  AST_Q_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_rise |=> q_hold_reg == $past(pipe_q_reg[RX_PIPE_LAST]))
    else $error("quadrature word not parked for the falling edge");

  // between conversion edges the rx word must stand for the host to sample it
  AST_BUS_STANDS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!conv_rise && !conv_fall) |=> $stable(shared_sample_bus_o))
    else $error("rx word moved between conversion edges");

  AST_TX_I_CLEAR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !in_tx |=> !tx_i_taken_reg)
    else $error("pending in-phase word kept outside tx mode");

  AST_LONE_RISE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (conv_rise && !tx_i_taken_reg) |=> $stable(txbuf_wr_reg) && !tx_overrun_o)
    else $error("rising edge without in-phase word pushed a pair");

  AST_PUSH_SLOT0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (txbuf_push && !txbuf_wr_reg) |=>
      txbuf_reg[0] == {$past(tx_i_hold_reg), $past(shared_sample_bus_i)})
    else $error("pair in slot 0 not in-phase then quadrature");

  AST_PUSH_SLOT1: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (txbuf_push && txbuf_wr_reg) |=>
      txbuf_reg[1] == {$past(tx_i_hold_reg), $past(shared_sample_bus_i)})
    else $error("pair in slot 1 not in-phase then quadrature");

  AST_OVERRUN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pair_done && !txbuf_ready) |=> tx_overrun_o && $stable(txbuf_wr_reg))
    else $error("dropped pair not flagged or still written");

  AST_PAIR_TOGETHER: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    txbuf_pop |=> tx_update_o
      && inphase_tx_sample_o == $past(txbuf_head[2*BUS_W-1:BUS_W])
      && quadrature_tx_sample_o == $past(txbuf_head[BUS_W-1:0]))
    else $error("dac words not taken together from the buffer head");

  // a dac word changing alone would put a false image on the analog pair
  AST_TX_HOLD: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !txbuf_pop |=> !tx_update_o && $stable(inphase_tx_sample_o)
      && $stable(quadrature_tx_sample_o))
    else $error("dac words moved without a buffer pop");

endmodule
`default_nettype wire

// ### include/afe_port_pkg.sv
`default_nettype none
package afe_port_pkg;

  localparam int unsigned   BUS_W         = 10;
  localparam int unsigned   TRIM_W        = 6;
  // rx pipeline stages clocked on conversion rising edges; the bus register adds
  // the last rising edge (in-phase) or the following falling edge (quadrature)
  localparam int unsigned   RX_PIPE_DEPTH = 5;
  localparam int unsigned   RX_PIPE_LAST  = RX_PIPE_DEPTH - 1;
  localparam int unsigned   TXBUF_DEPTH   = 2;
  localparam int unsigned   TXBUF_CNT_W   = 2;

  localparam logic [BUS_W-1:0]       BUS_RST       = 10'h000;
  localparam logic [BUS_W-1:0]       MIDSCALE_CODE = 10'h200;
  localparam logic [TRIM_W-1:0]      TRIM_RST      = 6'h00;
  localparam logic [TXBUF_CNT_W-1:0] TXBUF_FULL    = 2'h2;

  // full-scale select: 0 gives the 410 mV setting, 1 the 500 mV setting
  localparam logic FS_SEL_410MV = 1'b0;
  localparam logic FS_SEL_500MV = 1'b1;

  // gray along quiet -> rx -> tx
  typedef enum logic [1:0] {
    MODE_QUIET = 2'b00,
    MODE_RX    = 2'b01,
    MODE_TX    = 2'b11
  } port_mode_e;

endpackage
`default_nettype wire

// ### bench/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import afe_port_pkg::*;
(
  input  wire logic             clk_sys_i,
  input  wire logic             tx_select_i,
  input  wire logic             host_drive_i,
  input  wire logic [BUS_W-1:0] host_word_i,
  input  wire logic [BUS_W-1:0] dev_word_i,
  input  wire logic             dev_oe_i,
  input  wire logic             dev_pullup_i,
  output logic      [BUS_W-1:0] bus_level_o
);
  logic [BUS_W-1:0] last_reg;
  logic             host_en;
  // host drives offset-binary I then Q words, only once the device neither drives nor pulls up
  assign host_en = host_drive_i & tx_select_i & ~dev_oe_i & ~dev_pullup_i;
  always_ff @(posedge clk_sys_i) begin
    last_reg <= bus_level_o;
  end
  // released bus never rests low; without pull-up it flips every cycle
  assign bus_level_o = dev_oe_i ? dev_word_i : host_en ? host_word_i :
                       dev_pullup_i ? {BUS_W{1'b1}} : ~last_reg;
endmodule
`default_nettype wire

// ### bench/test_afe_muxed_iq_data_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_afe_muxed_iq_data_port;
  import afe_port_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              rst_i     = 1'b1;
  logic              conv_clk  = 1'b0;
  logic              tx_select = 1'b0;
  logic              pwr_off_n = 1'b1;
  logic              idle      = 1'b0;
  logic              hold      = 1'b0;
  logic              fs_sel    = 1'b0;
  logic [TRIM_W-1:0] itrim     = 6'h00;
  logic [TRIM_W-1:0] qtrim     = 6'h00;
  logic [BUS_W-1:0]  ich       = 10'h000;
  logic [BUS_W-1:0]  qch       = 10'h000;
  logic              host_drv  = 1'b0;
  logic [BUS_W-1:0]  host_word = 10'h000;
  logic              dac_rdy   = 1'b0;
  wire logic [BUS_W-1:0]  bus_lvl, bus_o, itx, qtx;
  wire logic              oe, pu, vld, upd, ovr, fs_o;
  wire logic [TRIM_W-1:0] it_o, qt_o;
  int bad_count = 0;
  int checks    = 0;
  int upd_n     = 0;
  int ovr_n     = 0;
  localparam logic [BUS_W-1:0] TAB [8] = '{10'h1FF, 10'h000, 10'h200, 10'h001,
                                           10'h3FF, 10'h155, 10'h0AA, 10'h2D2};

  afe_muxed_iq_data_port dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .conv_clk_i(conv_clk),
    .tx_select_i(tx_select), .power_off_state_n_i(pwr_off_n), .idle_state_i(idle),
    .low_power_hold_state_i(hold), .full_scale_sel_i(fs_sel), .inphase_trim_i(itrim),
    .quadrature_trim_i(qtrim), .inphase_rx_channel_i(ich), .quadrature_rx_channel_i(qch),
    .shared_sample_bus_i(bus_lvl), .shared_sample_bus_o(bus_o), .shared_sample_bus_oe_o(oe),
    .shared_sample_bus_pullup_o(pu), .dac_ready_i(dac_rdy), .dac_valid_o(vld),
    .inphase_tx_sample_o(itx), .quadrature_tx_sample_o(qtx), .tx_update_o(upd),
    .tx_overrun_o(ovr), .full_scale_sel_o(fs_o), .inphase_trim_o(it_o),
    .quadrature_trim_o(qt_o));
  host_bus_model host (.clk_sys_i(clk_sys_i), .tx_select_i(tx_select), .host_drive_i(host_drv),
    .host_word_i(host_word), .dev_word_i(bus_o), .dev_oe_i(oe), .dev_pullup_i(pu),
    .bus_level_o(bus_lvl));

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (upd === 1'b1) upd_n++;
    if (ovr === 1'b1) ovr_n++;
  end

  task automatic check(input logic [BUS_W-1:0] got, input logic [BUS_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one conversion half period (10 MHz conversion clock)
  task automatic half();
    @(posedge clk_sys_i);
    #1 conv_clk = ~conv_clk;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic complete_run();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic reset_values();
    check(BUS_W'({oe, pu, vld}), 10'h002);
    check(itx, MIDSCALE_CODE);
    check(qtx, MIDSCALE_CODE);
  endtask
  // rise k samples TAB[k]; five rises later I shows, the falling edge after that Q
  task automatic rx_path();
    for (int k = 0; k < 13; k++) begin
      ich = TAB[k % 8];
      qch = TAB[(k + 3) % 8];
      half();
      if (k >= 5) check(bus_o, TAB[k-5] ^ 10'h200);
      half();
      if (k >= 5) check(bus_o, TAB[(k-2) % 8] ^ 10'h200);
    end
    check(BUS_W'({oe, pu}), 10'h002);
    check(bus_lvl, bus_o);
  endtask
  task automatic quiet_states();
    for (int st = 0; st < 3; st++) begin
      pwr_off_n = (st != 0);
      idle = (st == 1);
      hold = (st == 2);
      tx_select = st[0];
      repeat (2) @(posedge clk_sys_i);
      #1 check(BUS_W'({oe, pu}), 10'h001);
      check(bus_lvl, 10'h3FF);
    end
    {pwr_off_n, idle, hold, tx_select} = 4'h8;
  endtask
  // lone rise first, then pairs; stall from pair 4 so pair 5 overflows
  task automatic tx_path();
    int ups;
    int ovs;
    ups = upd_n;
    ovs = ovr_n;
    {tx_select, host_drv, dac_rdy} = 3'h7;
    half();
    for (int p = 0; p < 6; p++) begin
      if (p == 4) dac_rdy = 1'b0;
      host_word = TAB[p];
      half();
      host_word = ~TAB[p];
      half();
      if (p >= 1) check(itx, TAB[p < 4 ? p - 1 : 2]);
      if (p >= 1) check(qtx, ~TAB[p < 4 ? p - 1 : 2]);
    end
    check(BUS_W'({oe, vld}), 10'h001);
    check(BUS_W'(ovr_n - ovs), 10'h001);
    {tx_select, host_drv, dac_rdy} = 3'h1;
    for (int d = 0; d < 3; d++) begin
      half();
      half();
      check(itx, TAB[d == 0 ? 3 : 4]);
      check(qtx, ~TAB[d == 0 ? 3 : 4]);
    end
    check(BUS_W'(upd_n - ups), 10'h005);
    check(BUS_W'(vld), 10'h000);
  endtask
  task automatic config_pass();
    for (int v = 0; v < 2; v++) begin
      fs_sel = v[0];
      itrim = v[0] ? 6'h2A : 6'h15;
      qtrim = ~itrim;
      repeat (2) @(posedge clk_sys_i);
      #1 check(BUS_W'(fs_o), BUS_W'(v[0]));
      check(BUS_W'(it_o), BUS_W'(itrim));
      check(BUS_W'(qt_o), BUS_W'(qtrim));
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    reset_values();
    rx_path();
    quiet_states();
    tx_path();
    config_pass();
    complete_run();
  end
  // whole run takes under 1000 cycles
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
